// >>> design/event_status_pkg.sv
// package of register map and field layout for the event/status registers
package event_status_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] EVENT_ADDR = 8'h00;
	localparam logic [7:0] LIVE_ADDR = 8'h01;
	localparam logic [7:0] EVENT_RESET = 8'h00;
	localparam logic [7:0] LIVE_RESET = 8'h00;
	localparam int REG_WIDTH = 8;
	// ==========================================================
	// field positions
	localparam int POWER_GOOD_BIT = 0;
	localparam int OVERCURRENT_BIT = 1;
	localparam int UNDERVOLTAGE_BIT = 2;
	localparam int SHORT_CIRCUIT_BIT = 3;
	localparam int SPARE_BIT = 4;
	localparam int PREWARNING_BIT = 5;
	localparam int WARNING_BIT = 6;
	localparam int SHUTDOWN_BIT = 7;
	// implemented bits, spare reads zero
	localparam logic [7:0] USED_MASK = 8'hEF;
endpackage : event_status_pkg

// >>> design/condition_sync.sv
// two-flop synchroniser and edge detector for the live condition inputs
`timescale 1ns/1ns
module condition_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic [WIDTH-1:0] cond_in, // raw conditions from pins
	output logic [WIDTH-1:0] cond_out, // synchronised level
	output logic [WIDTH-1:0] change_out // pulse on either edge
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;
	logic [WIDTH-1:0] prev_reg;
	logic [WIDTH-1:0] prev_next;

	// ==========================================================
	// next values
	always_comb begin
		meta_next = cond_in;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	// registers, all clear at reset
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	assign cond_out = sync_reg;
	assign change_out = sync_reg ^ prev_reg;
endmodule : condition_sync

// >>> design/regulator_event_status_regs.sv
// event latch and live condition registers of the regulator
`timescale 1ns/1ns
module regulator_event_status_regs (
	input wire logic SYS_CLK, // 10 MHz logic clock
	input wire logic SYS_RST, // synchronous reset, high
	input wire logic POWER_GOOD_LIVE, // output within range
	input wire logic OUTPUT_OVERCURRENT_LIVE, // current over limit
	input wire logic INPUT_UNDERVOLTAGE_LIVE, // input below threshold
	input wire logic SHORT_CIRCUIT_LIVE, // short circuit seen
	input wire logic THERMAL_PREWARNING_LIVE, // above pre-warning
	input wire logic THERMAL_WARNING_LIVE, // above warning
	input wire logic THERMAL_SHUTDOWN_LIVE, // above shutdown
	input wire logic RD_STROBE, // one-cycle read request
	input wire logic [7:0] RD_ADDR, // register address
	output logic [7:0] RD_DATA, // read data, registered
	output logic RD_VALID, // pulse, data valid
	output logic [7:0] EVENT_BITS // latched events, registered
);
	// ==========================================================
	// internal nets
	// raw condition vector, spare slot held low
	logic [7:0] raw_cond;
	// synchronised level of every condition
	logic [7:0] live_cond;
	// one-cycle pulse on any change of a condition
	logic [7:0] change;
	// changes split by direction, then merged
	logic [7:0] rise_hit;
	logic [7:0] fall_hit;
	logic [7:0] set_hit;
	// latched events
	logic [7:0] event_reg;
	logic [7:0] event_next;
	// read images of the two registers
	logic [7:0] event_view;
	logic [7:0] live_view;
	// read port state
	logic [7:0] data_reg;
	logic [7:0] data_next;
	logic valid_reg;
	logic valid_next;
	// decoded read requests
	logic event_read;
	logic live_read;
	// named event fields
	logic power_good_event;
	logic output_overcurrent_event;
	logic input_undervoltage_event;
	logic short_circuit_event;
	logic thermal_prewarning_event;
	logic thermal_warning_event;
	logic thermal_shutdown_event;

	// ==========================================================
	// address decode, shared by the latch clear and the read mux
	function automatic logic addr_hit(
		input logic strobe,
		input logic [7:0] addr,
		input logic [7:0] target
	);
		// a request counts only while its strobe is high
		return strobe && (addr == target);
	endfunction : addr_hit

	// ==========================================================
	// condition gathering, spare bit tied low
	always_comb begin
		raw_cond = '0;
		raw_cond[event_status_pkg::POWER_GOOD_BIT] = POWER_GOOD_LIVE;
		raw_cond[event_status_pkg::OVERCURRENT_BIT] = OUTPUT_OVERCURRENT_LIVE;
		raw_cond[event_status_pkg::UNDERVOLTAGE_BIT] = INPUT_UNDERVOLTAGE_LIVE;
		raw_cond[event_status_pkg::SHORT_CIRCUIT_BIT] = SHORT_CIRCUIT_LIVE;
		raw_cond[event_status_pkg::PREWARNING_BIT] = THERMAL_PREWARNING_LIVE;
		raw_cond[event_status_pkg::WARNING_BIT] = THERMAL_WARNING_LIVE;
		raw_cond[event_status_pkg::SHUTDOWN_BIT] = THERMAL_SHUTDOWN_LIVE;
	end

	// pins synchronised, edges detected
	condition_sync #(
		.WIDTH(event_status_pkg::REG_WIDTH)
	) u_sync (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.cond_in(raw_cond),
		.cond_out(live_cond),
		.change_out(change)
	);

	// ==========================================================
	// edge qualification, one slice per register bit
	generate
		for (genvar i = 0; i < event_status_pkg::REG_WIDTH; i++) begin : g_edge
			assign rise_hit[i] = change[i] & live_cond[i];
			assign fall_hit[i] = change[i] & ~live_cond[i];
			// spare slot never latches
			assign set_hit[i] = (rise_hit[i] | fall_hit[i])
				& event_status_pkg::USED_MASK[i];
		end
	endgenerate

	// ==========================================================
	// read request decode
	always_comb begin
		event_read = addr_hit(RD_STROBE, RD_ADDR,
			event_status_pkg::EVENT_ADDR);
		live_read = addr_hit(RD_STROBE, RD_ADDR,
			event_status_pkg::LIVE_ADDR);
	end

	// ==========================================================
	// event latch
	// clear on read, then any edge sets; no event lost to a clear
	always_comb begin
		event_next = event_reg;
		if (event_read) begin
			event_next = event_status_pkg::EVENT_RESET;
		end
		// edge sets, set wins over clear
		event_next = event_next | set_hit;
	end

	// latch register, cleared at reset
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			event_reg <= event_status_pkg::EVENT_RESET;
		end else begin
			event_reg <= event_next;
		end
	end

	// ==========================================================
	// named event fields
	// power good event
	assign power_good_event =
		event_reg[event_status_pkg::POWER_GOOD_BIT];
	assign output_overcurrent_event =
		event_reg[event_status_pkg::OVERCURRENT_BIT];
	assign input_undervoltage_event =
		event_reg[event_status_pkg::UNDERVOLTAGE_BIT];
	// short circuit event
	assign short_circuit_event =
		event_reg[event_status_pkg::SHORT_CIRCUIT_BIT];
	assign thermal_prewarning_event =
		event_reg[event_status_pkg::PREWARNING_BIT];
	assign thermal_warning_event =
		event_reg[event_status_pkg::WARNING_BIT];
	// thermal shutdown event
	assign thermal_shutdown_event =
		event_reg[event_status_pkg::SHUTDOWN_BIT];

	// event register image, spare slot reads zero
	always_comb begin
		event_view = '0;
		event_view[event_status_pkg::POWER_GOOD_BIT] = power_good_event;
		event_view[event_status_pkg::OVERCURRENT_BIT] =
			output_overcurrent_event;
		event_view[event_status_pkg::UNDERVOLTAGE_BIT] =
			input_undervoltage_event;
		event_view[event_status_pkg::SHORT_CIRCUIT_BIT] = short_circuit_event;
		event_view[event_status_pkg::PREWARNING_BIT] =
			thermal_prewarning_event;
		event_view[event_status_pkg::WARNING_BIT] = thermal_warning_event;
		event_view[event_status_pkg::SHUTDOWN_BIT] = thermal_shutdown_event;
	end

	// ==========================================================
	// live register image, unlatched
	// live image follows the synchronised levels
	always_comb begin
		live_view = '0;
		live_view[event_status_pkg::POWER_GOOD_BIT] =
			live_cond[event_status_pkg::POWER_GOOD_BIT];
		live_view[event_status_pkg::OVERCURRENT_BIT] =
			live_cond[event_status_pkg::OVERCURRENT_BIT];
		live_view[event_status_pkg::UNDERVOLTAGE_BIT] =
			live_cond[event_status_pkg::UNDERVOLTAGE_BIT];
		live_view[event_status_pkg::SHORT_CIRCUIT_BIT] =
			live_cond[event_status_pkg::SHORT_CIRCUIT_BIT];
		live_view[event_status_pkg::PREWARNING_BIT] =
			live_cond[event_status_pkg::PREWARNING_BIT];
		live_view[event_status_pkg::WARNING_BIT] =
			live_cond[event_status_pkg::WARNING_BIT];
		live_view[event_status_pkg::SHUTDOWN_BIT] =
			live_cond[event_status_pkg::SHUTDOWN_BIT];
	end

	// ==========================================================
	// read port
	// next read data: answer one cycle after the strobe
	always_comb begin
		data_next = data_reg;
		valid_next = RD_STROBE;
		if (event_read) begin
			data_next = event_view;
		end else if (live_read) begin
			data_next = live_view;
		end else if (RD_STROBE) begin
			// unmapped addresses read zero
			data_next = '0;
		end
	end

	// read registers, data holds until the next read
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			data_reg <= event_status_pkg::LIVE_RESET;
			valid_reg <= 1'b0;
		end else begin
			data_reg <= data_next;
			valid_reg <= valid_next;
		end
	end

	// ==========================================================
	// outputs, all straight from flip-flops
	assign RD_DATA = data_reg;
	assign RD_VALID = valid_reg;
	assign EVENT_BITS = event_reg;
endmodule : regulator_event_status_regs

// >>> verification/event_status_props.sv
// checker of read timing and event latching
`timescale 1ns/1ns
module event_status_props (
	input wire logic SYS_CLK, // clock
	input wire logic SYS_RST, // reset, high
	input wire logic RD_STROBE, // read request
	input wire logic RD_VALID, // answer pulse
	input wire logic [7:0] RD_ADDR, // read address
	input wire logic [7:0] RD_DATA, // read data
	input wire logic [7:0] EVENT_BITS, // latched events
	input wire logic OUTPUT_OVERCURRENT_LIVE, // raw overcurrent pin
	input wire logic THERMAL_WARNING_LIVE // raw warning pin
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	// event register read
	sequence rd_ev;
		RD_STROBE && RD_ADDR == 8'h00;
	endsequence
	// live register read with the synchroniser out of reset
	sequence rd_live;
		RD_STROBE && RD_ADDR == 8'h01 && !$past(SYS_RST, 2) && !$past(SYS_RST);
	endsequence
	// a change seen on a raw condition pin
	sequence oc_edge;
		$changed(OUTPUT_OVERCURRENT_LIVE);
	endsequence
	sequence warn_edge;
		$changed(THERMAL_WARNING_LIVE);
	endsequence
	chk_live_current: assert property (
		rd_live |=> RD_DATA[1] == $past(OUTPUT_OVERCURRENT_LIVE, 3))
		else $error("live current");
	chk_live_warning: assert property (
		rd_live |=> RD_DATA[6] == $past(THERMAL_WARNING_LIVE, 3))
		else $error("live warning");
	chk_edge_current: assert property (
		oc_edge |-> ##3 EVENT_BITS[1]) else $error("edge current");
	chk_edge_warning: assert property (
		warn_edge |-> ##3 EVENT_BITS[6]) else $error("edge warning");
	chk_valid_late: assert property (RD_STROBE |=> RD_VALID)
		else $error("valid");
	chk_valid_pulse: assert property (!RD_STROBE |=> !RD_VALID)
		else $error("pulse");
	chk_event_data: assert property (
		rd_ev |=> RD_DATA == $past(EVENT_BITS)) else $error("event");
	chk_event_sticky: assert property (
		!RD_STROBE |=> !(~EVENT_BITS & $past(EVENT_BITS))) else $error("lost");
	chk_data_holds: assert property (
		!RD_STROBE |=> $stable(RD_DATA)) else $error("data");
	chk_unmapped_zero: assert property (
		RD_STROBE && RD_ADDR > 8'h01 |=> RD_DATA == 8'h00) else $error("map");
endmodule : event_status_props
bind regulator_event_status_regs event_status_props chk_u (.*);

// >>> verification/host_model.sv
// host issuing single register reads
`timescale 1ns/1ns
module host_model (
	input wire logic clk, // clock
	output logic strobe = 1'b0, // read request
	output logic [7:0] addr = 8'h00 // address
);
	task automatic rd(input logic [7:0] a, input int gap);
		@(negedge clk) {strobe, addr} = {1'b1, a};
		@(negedge clk) {strobe, addr} = {1'b0, ~a};
		repeat (gap) @(negedge clk);
	endtask : rd
endmodule : host_model

// >>> verification/testbench.sv
// bench for the event and live registers
`timescale 1ns/1ns
module testbench;
	logic SYS_CLK = 1'b0, SYS_RST = 1'b1, RD_STROBE, RD_VALID;
	logic [7:0] RD_ADDR, RD_DATA, EVENT_BITS;
	logic [7:0] c = 8'h00, seed = 8'h61, exp_q [$];
	int fails = 0, n_tests = 0, cyc = 0;
	initial forever #50 SYS_CLK = ~SYS_CLK;
	regulator_event_status_regs dut_u (.SYS_CLK, .SYS_RST, .RD_STROBE,
		.RD_ADDR, .RD_DATA, .RD_VALID, .EVENT_BITS, .POWER_GOOD_LIVE(c[0]),
		.OUTPUT_OVERCURRENT_LIVE(c[1]), .INPUT_UNDERVOLTAGE_LIVE(c[2]),
		.SHORT_CIRCUIT_LIVE(c[3]), .THERMAL_PREWARNING_LIVE(c[5]),
		.THERMAL_WARNING_LIVE(c[6]), .THERMAL_SHUTDOWN_LIVE(c[7]));
	host_model host_u (.clk(SYS_CLK), .strobe(RD_STROBE), .addr(RD_ADDR));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic cmp8(input logic [7:0] e, g);
		n_tests++;
		if (g !== e) fails++;
		if (g !== e) $display("mismatch rd_data exp %h got %h", e, g);
	endtask : cmp8
	task automatic cmp_events(input logic [7:0] e, g);
		n_tests++;
		if (g !== e) fails++;
		if (g !== e) $display("mismatch event_bits exp %h got %h", e, g);
	endtask : cmp_events
	task automatic report_and_stop;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	// oldest note against each answer, capped run
	always @(negedge SYS_CLK) begin
		cyc++;
		if (RD_VALID === 1'b1 && exp_q.size() == 0) begin
			fails++;
			$display("mismatch rd_valid exp 0 got 1");
		end else if (RD_VALID === 1'b1) begin
			cmp8(exp_q.pop_front(), RD_DATA);
		end
		if (cyc == 2000) begin
			fails++;
			report_and_stop();
		end
	end
	// random rise then fall of conditions, four reads each
	initial begin
		repeat (4) @(negedge SYS_CLK);
		SYS_RST = 1'b0;
		for (int i = 0; i < 24; i++) begin
			if (!i[0]) seed = lfsr(seed);
			c = i[0] ? 8'h00 : seed & 8'hEF;
			repeat (4) @(negedge SYS_CLK);
			cmp_events(seed & 8'hEF, EVENT_BITS);
			exp_q.push_back(c);
			exp_q.push_back(seed & 8'hEF);
			exp_q.push_back(8'h00);
			exp_q.push_back(8'h00);
			host_u.rd(8'h01, i % 3);
			host_u.rd(8'h00, 1);
			host_u.rd(8'h00, 0);
			host_u.rd(seed | 8'h02, 2);
			cmp_events(8'h00, EVENT_BITS);
		end
		if (exp_q.size() != 0) begin
			fails++;
			$display("mismatch pending_reads exp 0 got %0d", exp_q.size());
		end
		report_and_stop();
	end
endmodule : testbench
